// File: pkg/pied_pkg.sv
// Constants for the posted interrupt entry decoder
package pied_pkg;
	// Remap table entry fields
	localparam int ENT_PRESENT_BIT   = 0;
	localparam int ENT_FAULT_OFF_BIT = 1;
	localparam int ENT_RSV_LO_MSB    = 7;
	localparam int ENT_RSV_LO_LSB    = 2;
	localparam int ENT_SWF_MSB       = 11;
	localparam int ENT_SWF_LSB       = 8;
	localparam int ENT_RSV_HI_MSB    = 13;
	localparam int ENT_RSV_HI_LSB    = 12;
	localparam int ENT_URGENT_BIT    = 14;
	localparam int ENT_MODE_BIT      = 15;
	localparam int ENT_VEC_LSB       = 16;
	localparam int ENT_DADDR_LSB     = 38;
	localparam int ENT_WIDTH         = 64;
	localparam int DADDR_WIDTH       = 26;
	localparam int DADDR_SHIFT       = 6;
	// Posting descriptor fields
	localparam int DSC_WIDTH         = 512;
	localparam int DSC_OUTST_BIT     = 256;
	localparam int DSC_MUTE_BIT      = 257;
	localparam int DSC_NVEC_LSB      = 272;
	localparam int DSC_TGT_LSB       = 288;
	localparam int DSC_TGT8_LSB      = 296;
	localparam int DSC_RSV_LSB       = 320;
	localparam int DSC_RSV_WIDTH     = 192;
	localparam int BITMAP_WIDTH      = 256;
	localparam int VEC_WIDTH         = 8;
	localparam int TGT_WIDTH         = 32;
	localparam int TGT8_WIDTH        = 8;
	// Register port map (word index on the plain port)
	localparam logic [3:0] ADR_CTRL     = 4'h0;
	localparam logic [3:0] ADR_ENT_LO   = 4'h1;
	localparam logic [3:0] ADR_ENT_HI   = 4'h2;
	localparam logic [3:0] ADR_STATUS   = 4'h3;
	localparam logic [3:0] ADR_OUTCOME  = 4'h4;
	localparam logic [3:0] ADR_DSC_CTL  = 4'h5;
	localparam logic [3:0] ADR_DSC_TGT  = 4'h6;
	localparam logic [3:0] ADR_BITMAP   = 4'h7;
	localparam logic [3:0] ADR_BM_SEL   = 4'h8;
	localparam logic [3:0] ADR_DADDR    = 4'h9;
	localparam logic [31:0] CTRL_RESET  = 32'h0000_0003;
	// Control bits
	localparam int CTRL_CAP_BIT    = 0;
	localparam int CTRL_X32_BIT    = 1;
	localparam int CTRL_GO_BIT     = 2;
	localparam int CTRL_CLRBM_BIT  = 3;
	typedef enum logic [2:0] {
		PIED_OUT_NONE,
		PIED_OUT_BLOCKED,
		PIED_OUT_FAULT,
		PIED_OUT_REMAP,
		PIED_OUT_POSTED
	} pied_outcome_t;
endpackage

// File: rtl/pied_decode.sv
// Combinational decode of one remap table entry
`timescale 1ns/100ps
`default_nettype none
module pied_decode (
	input  wire logic [63:0] entry,
	input  wire logic        posting_capable,
	output logic             present,
	output logic             fault_log_off,
	output logic             posted,
	output logic             latency_critical,
	output logic             rsv_error,
	output logic [7:0]       guest_vector,
	output logic [25:0]      descr_addr_low
);
	logic mode_raw;
	logic urg_raw;
	always_comb begin
		present          = entry[pied_pkg::ENT_PRESENT_BIT];
		fault_log_off    = entry[pied_pkg::ENT_FAULT_OFF_BIT];
		mode_raw         = entry[pied_pkg::ENT_MODE_BIT];
		urg_raw          = entry[pied_pkg::ENT_URGENT_BIT];
		posted           = present && posting_capable && mode_raw;
		latency_critical = posted && urg_raw;
		guest_vector     = entry[pied_pkg::ENT_VEC_LSB +: pied_pkg::VEC_WIDTH];
		descr_addr_low   = entry[pied_pkg::ENT_DADDR_LSB +: pied_pkg::DADDR_WIDTH];
		// Software field is never looked at
		rsv_error = present && (
			(|entry[pied_pkg::ENT_RSV_HI_MSB:pied_pkg::ENT_RSV_HI_LSB]) ||
			(|entry[pied_pkg::ENT_RSV_LO_MSB:pied_pkg::ENT_RSV_LO_LSB]) ||
			(!posting_capable && (mode_raw || urg_raw)));
	end
endmodule
`default_nettype wire

// File: rtl/pied_top.sv
// Posted interrupt entry decoder with descriptor image and register port
//
// Strobed register access and the address map were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - Guest vector from entry bits 23:16
// - Mode bit 15 selects posted or remapped
// - Without posting, mode and urgency are reserved
// - Urgency bit 14 marks latency-critical
// - Urgency consulted only when valid and posted
// - Software bits 11:8 are ignored
// - Bit 1 suppresses fault recording
// - Fault suppression honoured regardless of valid
// - Bit 0 clear blocks every request
// - Bit 0 set processes per fields
// - Descriptor is 64 bytes, 64-byte aligned
// - 8-bit target from bits 303:296
// - 32-bit target uses bits 319:288
// - Entry bits 63:38 give address 31:6
// - Set outstanding, notify only if clear
// - Mute with non-urgent: no notify, no change
// - Notify edge, asserted, with vector 279:272
module pied_top (
	input  wire logic        REF_CLK,
	input  wire logic        RST_N,
	input  wire logic [3:0]  ADDR,
	input  wire logic [31:0] WDATA,
	input  wire logic        WR,
	input  wire logic        RD,
	output logic [31:0]      RDATA,
	output logic             NOTIFY,
	output logic [7:0]       NOTIFY_VECTOR,
	output logic [31:0]      NOTIFY_TARGET,
	output logic             FAULT_REPORT,
	output logic [31:0]      DESCR_ADDR
);
	logic [31:0]  ctrl_reg;
	logic [63:0]  entry_reg;
	logic [255:0] bitmap_reg;
	logic         outst_reg;
	logic         mute_reg;
	logic [7:0]   dsc_nvec_reg;
	logic [31:0]  dsc_tgt_reg;
	logic [2:0]   bm_sel_reg;
	logic [31:0]  rdata_reg;
	logic         notify_reg;
	logic [7:0]   nvec_reg;
	logic [31:0]  ntgt_reg;
	logic         fault_reg;
	logic [31:0]  daddr_reg;
	logic [31:0]  post_cnt_reg;
	logic [31:0]  block_cnt_reg;
	pied_pkg::pied_outcome_t outcome_reg;
	logic         d_present;
	logic         d_fault_off;
	logic         d_posted;
	logic         d_urgent;
	logic         d_rsv_err;
	logic [7:0]   d_vector;
	logic [25:0]  d_daddr;
	logic         go;
	logic         muted;
	logic         outst;
	logic         do_post;
	logic         send_notify;
	logic         clr_bm;
	logic         refused;
	logic [31:0]  tgt_next;
	logic [31:0]  rdata_next;

	pied_decode u_decode (
		.entry            (entry_reg),
		.posting_capable  (ctrl_reg[pied_pkg::CTRL_CAP_BIT]),
		.present          (d_present),
		.fault_log_off    (d_fault_off),
		.posted           (d_posted),
		.latency_critical (d_urgent),
		.rsv_error        (d_rsv_err),
		.guest_vector     (d_vector),
		.descr_addr_low   (d_daddr)
	);

	// A request is issued by writing the go bit of the control word
	assign go = WR && (ADDR == pied_pkg::ADR_CTRL) && WDATA[pied_pkg::CTRL_GO_BIT];
	assign clr_bm = WR && (ADDR == pied_pkg::ADR_CTRL) && WDATA[pied_pkg::CTRL_CLRBM_BIT];
	assign refused = go && (!d_present || d_rsv_err);
	assign outst = outst_reg;
	assign muted = mute_reg && !d_urgent;
	assign do_post = go && d_present && !d_rsv_err && d_posted;
	assign send_notify = do_post && !muted && !outst;

	always_comb begin
		if (ctrl_reg[pied_pkg::CTRL_X32_BIT]) begin
			tgt_next = dsc_tgt_reg;
		end else begin
			tgt_next = {24'h00_0000, dsc_tgt_reg[
				pied_pkg::DSC_TGT8_LSB - pied_pkg::DSC_TGT_LSB +: pied_pkg::TGT8_WIDTH]};
		end
	end

	// Control word
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			ctrl_reg <= pied_pkg::CTRL_RESET;
		end else if (WR && ADDR == pied_pkg::ADR_CTRL) begin
			ctrl_reg <= {30'h0000_0000, WDATA[1:0]};
		end
	end

	// Entry image
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			entry_reg <= 64'h0000_0000_0000_0000;
		end else if (WR && ADDR == pied_pkg::ADR_ENT_LO) begin
			entry_reg[31:0] <= WDATA;
		end else if (WR && ADDR == pied_pkg::ADR_ENT_HI) begin
			entry_reg[63:32] <= WDATA;
		end
	end

	// Bitmap word select
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			bm_sel_reg <= 3'h0;
		end else if (WR && ADDR == pied_pkg::ADR_BM_SEL) begin
			bm_sel_reg <= WDATA[2:0];
		end
	end

	// Pending request bitmap, one flip-flop per vector; a post beats a clear
	for (genvar i = 0; i < pied_pkg::BITMAP_WIDTH; i++) begin : g_bitmap
		always_ff @(posedge REF_CLK or negedge RST_N) begin
			if (!RST_N) begin
				bitmap_reg[i] <= 1'b0;
			end else if (do_post && d_vector == 8'(i)) begin
				bitmap_reg[i] <= 1'b1;
			end else if (clr_bm) begin
				bitmap_reg[i] <= 1'b0;
			end
		end
	end

	// Outstanding flag: a notifying post wins over a software write
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			outst_reg <= 1'b0;
		end else if (do_post && !muted) begin
			outst_reg <= 1'b1;
		end else if (WR && ADDR == pied_pkg::ADR_DSC_CTL) begin
			outst_reg <= WDATA[0];
		end
	end

	// Mute flag, software owned
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			mute_reg <= 1'b0;
		end else if (WR && ADDR == pied_pkg::ADR_DSC_CTL) begin
			mute_reg <= WDATA[1];
		end
	end

	// Notification vector field, software owned
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			dsc_nvec_reg <= 8'h00;
		end else if (WR && ADDR == pied_pkg::ADR_DSC_CTL) begin
			dsc_nvec_reg <= WDATA[15:8];
		end
	end

	// Notification target word; the reserved upper area is not stored
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			dsc_tgt_reg <= 32'h0000_0000;
		end else if (WR && ADDR == pied_pkg::ADR_DSC_TGT) begin
			dsc_tgt_reg <= WDATA;
		end
	end

	// Notification pulse, one cycle per accepted notify
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			notify_reg <= 1'b0;
		end else begin
			notify_reg <= send_notify;
		end
	end

	// Vector carried by the notification, held until the next one
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			nvec_reg <= 8'h00;
		end else if (send_notify) begin
			nvec_reg <= dsc_nvec_reg;
		end
	end

	// Target carried by the notification, held until the next one
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			ntgt_reg <= 32'h0000_0000;
		end else if (send_notify) begin
			ntgt_reg <= tgt_next;
		end
	end

	// Fault report pulse for a blocked or faulted request
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			fault_reg <= 1'b0;
		end else if (refused) begin
			fault_reg <= !d_fault_off;
		end else begin
			fault_reg <= 1'b0;
		end
	end

	// Outcome of the last request
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			outcome_reg <= pied_pkg::PIED_OUT_NONE;
		end else if (go) begin
			if (!d_present) begin
				outcome_reg <= pied_pkg::PIED_OUT_BLOCKED;
			end else if (d_rsv_err) begin
				outcome_reg <= pied_pkg::PIED_OUT_FAULT;
			end else if (d_posted) begin
				outcome_reg <= pied_pkg::PIED_OUT_POSTED;
			end else begin
				outcome_reg <= pied_pkg::PIED_OUT_REMAP;
			end
		end
	end

	// Count of posted requests
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			post_cnt_reg <= 32'h0000_0000;
		end else if (do_post) begin
			post_cnt_reg <= post_cnt_reg + 32'h0000_0001;
		end
	end

	// Count of blocked or faulted requests
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			block_cnt_reg <= 32'h0000_0000;
		end else if (refused) begin
			block_cnt_reg <= block_cnt_reg + 32'h0000_0001;
		end
	end

	// Descriptor address, 64-byte aligned
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			daddr_reg <= 32'h0000_0000;
		end else begin
			daddr_reg <= {d_daddr, 6'h00};
		end
	end

	// Read mux
	always_comb begin
		case (ADDR)
			pied_pkg::ADR_CTRL:    rdata_next = ctrl_reg;
			pied_pkg::ADR_ENT_LO:  rdata_next = entry_reg[31:0];
			pied_pkg::ADR_ENT_HI:  rdata_next = entry_reg[63:32];
			pied_pkg::ADR_STATUS:  rdata_next = {23'h00_0000, d_vector,
				d_rsv_err};
			pied_pkg::ADR_OUTCOME: rdata_next = {post_cnt_reg[15:0],
				block_cnt_reg[12:0], outcome_reg};
			pied_pkg::ADR_DSC_CTL: rdata_next = {16'h0000, dsc_nvec_reg, 6'h00,
				mute_reg, outst_reg};
			pied_pkg::ADR_DSC_TGT: rdata_next = dsc_tgt_reg;
			pied_pkg::ADR_BITMAP:  rdata_next = bitmap_reg[{bm_sel_reg, 5'h00} +: 32];
			pied_pkg::ADR_BM_SEL:  rdata_next = {29'h0000_0000, bm_sel_reg};
			pied_pkg::ADR_DADDR:   rdata_next = daddr_reg;
			default:               rdata_next = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			rdata_reg <= 32'h0000_0000;
		end else if (RD) begin
			rdata_reg <= rdata_next;
		end else begin
			rdata_reg <= 32'h0000_0000;
		end
	end

	assign RDATA         = rdata_reg;
	assign NOTIFY        = notify_reg;
	assign NOTIFY_VECTOR = nvec_reg;
	assign NOTIFY_TARGET = ntgt_reg;
	assign FAULT_REPORT  = fault_reg;
	assign DESCR_ADDR    = daddr_reg;
endmodule
`default_nettype wire

// File: testbench/pied_assertions.sv
// Port assertions for the posted interrupt decoder
`timescale 1ns/100ps
`default_nettype none
module pied_chk (
	input wire logic        REF_CLK,
	input wire logic        RST_N,
	input wire logic [3:0]  ADDR,
	input wire logic [31:0] WDATA,
	input wire logic        WR,
	input wire logic        RD,
	input wire logic [31:0] RDATA,
	input wire logic        NOTIFY,
	input wire logic [7:0]  NOTIFY_VECTOR,
	input wire logic [31:0] NOTIFY_TARGET,
	input wire logic        FAULT_REPORT,
	input wire logic [31:0] DESCR_ADDR
);
	logic x32_reg;
	logic x32_req_reg;
	logic fpd_reg;
	logic pres_reg;
	wire  go = WR && ADDR == 4'h0 && WDATA[2];
	// Mirrors the target width mode held in control
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) x32_reg <= 1'b1;
		else if (WR && ADDR == 4'h0) x32_reg <= WDATA[1];
	end
	// Mode in force when a request was taken, before its own write
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) x32_req_reg <= 1'b1;
		else if (go) x32_req_reg <= x32_reg;
	end
	// Mirrors the valid and fault-suppression bits of the entry
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			fpd_reg  <= 1'b0;
			pres_reg <= 1'b0;
		end else if (WR && ADDR == 4'h1) begin
			fpd_reg  <= WDATA[1];
			pres_reg <= WDATA[0];
		end
	end
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!RST_N);
	property p_daddr; WR && ADDR == 4'h2 |=> ##1
		DESCR_ADDR == {$past(WDATA[31:6], 2), 6'h00}; endproperty
	a_daddr: assert property (p_daddr) else $error("descriptor address");
	property p_pulse; NOTIFY |=> !NOTIFY; endproperty
	a_pulse: assert property (p_pulse) else $error("notify too long");
	property p_ncause; NOTIFY |-> $past(go); endproperty
	a_ncause: assert property (p_ncause) else $error("notify without request");
	property p_fcause; FAULT_REPORT |-> $past(go); endproperty
	a_fcause: assert property (p_fcause) else $error("fault without request");
	property p_excl; !(NOTIFY && FAULT_REPORT); endproperty
	a_excl: assert property (p_excl) else $error("notify on fault");
	property p_vhold; !NOTIFY |-> $stable(NOTIFY_VECTOR); endproperty
	a_vhold: assert property (p_vhold) else $error("vector moved");
	property p_thold; !NOTIFY |-> $stable(NOTIFY_TARGET); endproperty
	a_thold: assert property (p_thold) else $error("target moved");
	property p_tgt8; NOTIFY && !x32_req_reg |-> NOTIFY_TARGET[31:8] == 24'h0; endproperty
	a_tgt8: assert property (p_tgt8) else $error("narrow target");
	property p_fsup; FAULT_REPORT |-> !fpd_reg; endproperty
	a_fsup: assert property (p_fsup) else $error("fault not suppressed");
	property p_npres; NOTIFY |-> pres_reg; endproperty
	a_npres: assert property (p_npres) else $error("notify from invalid entry");
endmodule
bind pied_top pied_chk chk_u (.REF_CLK(REF_CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA),
	.WR(WR), .RD(RD), .RDATA(RDATA), .NOTIFY(NOTIFY), .NOTIFY_VECTOR(NOTIFY_VECTOR),
	.NOTIFY_TARGET(NOTIFY_TARGET), .FAULT_REPORT(FAULT_REPORT), .DESCR_ADDR(DESCR_ADDR));
`default_nettype wire

// File: testbench/pied_mem_model.sv
// Host memory image of entries and descriptor target
`timescale 1ns/100ps
`default_nettype none
module pied_mem_model (
	input  wire logic [2:0] sel,
	output logic [63:0]     ent,
	output logic [31:0]     dsc_tgt
);
	// Coherent image, upper descriptor bits stay zero
	assign dsc_tgt = 32'h1234_5678;
	always_comb begin
		case (sel) // Reserved bits zero except entry 4
			3'h0: ent = 64'h0000_1FC0_005A_8F01;
			3'h1: ent = 64'h0000_1FC0_0033_C001;
			3'h2: ent = 64'h0000_0000_0000_8000;
			3'h3: ent = 64'h0000_0000_0000_0002;
			3'h4: ent = 64'h0000_0000_0000_3001;
			default: ent = 64'h0000_0000_0011_0001;
		endcase
	end
endmodule
`default_nettype wire

// File: testbench/testbench.sv
// Self-checking bench for the posted interrupt decoder
`timescale 1ns/100ps
`default_nettype none
module testbench;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [3:0]  addr = 4'h0;
	logic [31:0] wdata = 32'h0;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic [31:0] rdata, ntgt, daddr, tgt;
	logic [7:0]  nvec;
	logic        notify, fault;
	logic [2:0]  sel = 3'h0;
	logic [63:0] ent;
	int          n_errors = 0;
	int          checks_done = 0;
	always #50 clk = ~clk;
	pied_top dut_u (.REF_CLK(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
		.RDATA(rdata), .NOTIFY(notify), .NOTIFY_VECTOR(nvec), .NOTIFY_TARGET(ntgt),
		.FAULT_REPORT(fault), .DESCR_ADDR(daddr));
	pied_mem_model mem_u (.sel(sel), .ent(ent), .dsc_tgt(tgt));
	task automatic chk(input string w, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected %s: expected %h seen %h", w, exp, seen);
		end
	endtask
	task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rchk(input string w, input logic [3:0] a, input logic [31:0] e,
		input logic [31:0] m = 32'hFFFF_FFFF);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk(w, rdata & m, e);
	endtask
	task automatic go(input logic [1:0] c, input logic n, input logic f);
		wr_reg(4'h0, {29'h0, 1'b1, c});
		#1 chk("notify", {31'h0, notify}, {31'h0, n});
		chk("fault", {31'h0, fault}, {31'h0, f});
	endtask
	task automatic load(input logic [2:0] s);
		sel = s;
		#1;
		wr_reg(4'h1, ent[31:0]);
		wr_reg(4'h2, ent[63:32]);
	endtask
	task automatic t_post;
		rchk("ctrl", 4'h0, 32'h3);
		rchk("unmapped", 4'hF, 32'h0);
		load(3'h0);
		wr_reg(4'h6, tgt);
		wr_reg(4'h5, 32'h3100);
		go(2'h3, 1'b1, 1'b0);
		chk("vector", {24'h0, nvec}, 32'h31);
		chk("target", ntgt, tgt);
		rchk("daddr", 4'h9, 32'h1FC0);
		chk("descr_addr", daddr, 32'h0000_1FC0);
		rchk("status", 4'h3, 32'hB4);
		wr_reg(4'h8, 32'h2);
		rchk("bitmap", 4'h7, 32'h0400_0000);
		go(2'h3, 1'b0, 1'b0);
		rchk("dsc", 4'h5, 32'h3101);
		rchk("outcome", 4'h4, 32'h0002_0004);
		$display("test post done");
	endtask
	task automatic t_mute;
		wr_reg(4'h5, 32'h3102);
		go(2'h3, 1'b0, 1'b0);
		rchk("dsc", 4'h5, 32'h3102);
		load(3'h1);
		wr_reg(4'h0, 32'h1);
		go(2'h1, 1'b1, 1'b0);
		chk("target8", ntgt, {24'h0, tgt[15:8]});
		wr_reg(4'h8, 32'h1);
		rchk("bitmap", 4'h7, 32'h0008_0000);
		$display("test mute done");
	endtask
	task automatic t_fault;
		load(3'h2);
		go(2'h3, 1'b0, 1'b1);
		rchk("blocked", 4'h4, 32'h1, 32'h7);
		load(3'h3);
		go(2'h3, 1'b0, 1'b0);
		load(3'h4);
		go(2'h3, 1'b0, 1'b1);
		rchk("rsv", 4'h3, 32'h1);
		load(3'h0);
		wr_reg(4'h0, 32'h0);
		go(2'h0, 1'b0, 1'b1);
		load(3'h5);
		go(2'h3, 1'b0, 1'b0);
		rchk("remap", 4'h4, 32'h3, 32'h7);
		wr_reg(4'h0, 32'h8);
		rchk("bitmap clear", 4'h7, 32'h0);
		$display("test fault done");
	endtask
	task automatic summarize;
		$display("checks %0d mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		t_post();
		t_mute();
		t_fault();
		summarize();
	end
	initial begin
		#200000;
		n_errors++;
		summarize();
	end
endmodule
`default_nettype wire
